// ---- hw/lcc_cfg.svh ----
// Function
// RULE1: the link receiver is switched off when the power-down bit is 1 and on when 0, only under software power-down control.
// RULE2: power-down source select 0 hands power-down to the supervision unit, 1 to the programmed register bits.
// RULE3: calibration select 0 takes the clock compensation delay from the supervision unit's automatic calibration.
// RULE4: calibration select 1 takes the clock compensation delay from the registers (manual control).
// RULE5: the manual delay field acts only while manual calibration is selected.
// RULE6: the manual delay is a 4-bit value in bits 3 to 0 of its register.
// RULE7: the link-domain reset is stretched by the programmed 8-bit count of link clock periods.
// RULE8: the converter-domain reset is stretched by the programmed 8-bit count of converter clock periods.
// RULE9: the supervision unit derives its interval from an 8-bit predivider counted in link clock periods.
// RULE10: a set domain reset bit holds that domain in reset, and its release is followed by the programmed stretch.
// RULE11: the simple error-rate bit enables the link bit-error check, and the low reserved bits stay 0.
`ifndef LCC_CFG_SVH
`define LCC_CFG_SVH
`define LCC_ADDR_MAIN      5'h00
`define LCC_ADDR_MANDLY    5'h01
`define LCC_ADDR_DEBUG     5'h02
`define LCC_ADDR_LINKEXT   5'h04
`define LCC_ADDR_CONVEXT   5'h05
`define LCC_ADDR_PREDIV    5'h06
`define LCC_ADDR_IOSEL1    5'h11
`define LCC_ADDR_IOSEL2    5'h12
`define LCC_ADDR_TYPE      5'h1b
`define LCC_ADDR_CONVREV   5'h1c
`define LCC_ADDR_DIGREV    5'h1d
`define LCC_ADDR_LINKREV   5'h1e
`define LCC_ADDR_PAGE      5'h1f
`define LCC_RST_MAIN       8'h03
`define LCC_RST_LINKEXT    8'h3f
`define LCC_RST_CONVEXT    8'h20
`define LCC_RST_PREDIV     8'h1d
`define LCC_RST_IOSEL      8'h80
`define LCC_BIT_LINKPD     4
`define LCC_BIT_PDSEL      3
`define LCC_BIT_CALSEL     2
`define LCC_BIT_CONVRST    1
`define LCC_BIT_LINKRST    0
`define LCC_BIT_SIMPLE_ERROR_RATE_TEST       3
`define LCC_SPI_FRAME      5'd16
`define LCC_SPI_HEADER     5'd8
`endif

// ---- hw/lcc_pkg.sv ----
package lcc_pkg;
  // serial side of the register port
  typedef struct packed {
    logic csN;
    logic sclk;
    logic sdi;
  } lcc_spi_in_s;
  typedef struct packed {
    logic sdo;
    logic sdoOe;
  } lcc_spi_out_s;
  // controls driven into the link front end
  typedef struct packed {
    logic       linkRxPowerdown;
    logic [3:0] clockDelay;
    logic       linkDomainReset;
    logic       convDomainReset;
    logic       simpleErrorTest;
    logic       supervisorTick;
  } lcc_ctrl_s;
  typedef enum logic [1:0] {
    LCC_IDLE   = 2'b00,
    LCC_HEADER = 2'b01,
    LCC_DATA   = 2'b10,
    LCC_DONE   = 2'b11
  } lcc_spi_e;
  typedef struct packed {
    logic [7:0]  mainCtl;
    logic [7:0]  manDelay;
    logic [7:0]  linkDbg;
    logic [7:0]  linkExt;
    logic [7:0]  convExt;
    logic [7:0]  preDiv;
    logic [7:0]  ioSel1;
    logic [7:0]  ioSel2;
    logic [2:0]  page;
    lcc_spi_e    phase;
    logic        sclkPrev;
    logic [4:0]  bitCnt;
    logic [15:0] shift;
    logic [7:0]  txShift;
    logic        readOp;
    logic        sdo;
    logic [7:0]  linkCnt;
    logic [7:0]  convCnt;
    logic [7:0]  divCnt;
    lcc_ctrl_s   ctrl;
  } lcc_state_s;
endpackage

// ---- hw/lcc_regs.sv ----
`timescale 1ns/1ps
`include "lcc_cfg.svh"
module lcc_regs #(
  parameter logic [2:0] OWN_PAGE  = 3'h0,
  parameter logic [7:0] TYPE_CODE = 8'h5a, // arbitrary identification value
  parameter logic [7:0] CONV_REV  = 8'h11, // arbitrary identification value
  parameter logic [7:0] DIG_REV   = 8'h12, // arbitrary identification value
  parameter logic [7:0] LINK_REV  = 8'h13  // arbitrary identification value
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // serial register port
  input  wire lcc_pkg::lcc_spi_in_s  spiIn,
  output lcc_pkg::lcc_spi_out_s      spiOut,
  // rate enables of the two clock domains
  input  wire logic               linkClkTick,
  input  wire logic               convClkTick,
  // supervision unit results
  input  wire logic               supervisorPowerdown,
  input  wire logic [3:0]         autoDelay,
  // controls to the link front end
  output lcc_pkg::lcc_ctrl_s         ctrl
);
  import lcc_pkg::*;

  lcc_state_s q;
  lcc_state_s d;
  logic       ownPage;

  assign ownPage = (q.page == OWN_PAGE);

  always_comb begin
    logic [15:0] nextShift;
    logic [7:0]  sel;
    logic        rise;
    logic        fall;
    nextShift = {q.shift[14:0], spiIn.sdi};
    rise      = spiIn.sclk && !q.sclkPrev;
    fall      = !spiIn.sclk && q.sclkPrev;
    sel       = 8'h00;
    d         = q;
    d.sclkPrev = spiIn.sclk;
    // read mux, page register visible on every page
    case (nextShift[4:0])
      `LCC_ADDR_PAGE:    sel = {5'h00, q.page};
      `LCC_ADDR_MAIN:    sel = ownPage ? q.mainCtl : 8'h00;
      `LCC_ADDR_MANDLY:  sel = ownPage ? q.manDelay : 8'h00;
      `LCC_ADDR_DEBUG:   sel = ownPage ? q.linkDbg : 8'h00;
      `LCC_ADDR_LINKEXT: sel = ownPage ? q.linkExt : 8'h00;
      `LCC_ADDR_CONVEXT: sel = ownPage ? q.convExt : 8'h00;
      `LCC_ADDR_PREDIV:  sel = ownPage ? q.preDiv : 8'h00;
      `LCC_ADDR_IOSEL1:  sel = ownPage ? q.ioSel1 : 8'h00;
      `LCC_ADDR_IOSEL2:  sel = ownPage ? q.ioSel2 : 8'h00;
      `LCC_ADDR_TYPE:    sel = ownPage ? TYPE_CODE : 8'h00;
      `LCC_ADDR_CONVREV: sel = ownPage ? CONV_REV : 8'h00;
      `LCC_ADDR_DIGREV:  sel = ownPage ? DIG_REV : 8'h00;
      `LCC_ADDR_LINKREV: sel = ownPage ? LINK_REV : 8'h00;
      default:           sel = 8'h00;
    endcase
    // frame: read flag, two spare bits, 5-bit address, then 8 data bits
    case (q.phase)
      LCC_IDLE: begin
        d.bitCnt = 5'd0;
        d.readOp = 1'b0;
        if (!spiIn.csN) begin
          d.phase = LCC_HEADER;
        end
      end
      LCC_HEADER: begin
        if (rise) begin
          d.shift  = nextShift;
          d.bitCnt = q.bitCnt + 5'd1;
          if (q.bitCnt + 5'd1 == `LCC_SPI_HEADER) begin
            d.readOp  = nextShift[7];
            d.sdo     = sel[7];
            d.txShift = {sel[6:0], 1'b0};
            d.phase   = LCC_DATA;
          end
        end
      end
      LCC_DATA: begin
        if (fall && q.readOp) begin
          d.sdo     = q.txShift[7];
          d.txShift = {q.txShift[6:0], 1'b0};
        end
        if (rise) begin
          d.shift  = nextShift;
          d.bitCnt = q.bitCnt + 5'd1;
          if (q.bitCnt + 5'd1 == `LCC_SPI_FRAME) begin
            d.phase = LCC_DONE;
            if (!q.readOp) begin
              // the address sits in bits 12:8 only once the 16th bit is in
              if (nextShift[12:8] == `LCC_ADDR_PAGE) begin
                d.page = nextShift[2:0];
              end else if (ownPage) begin
                case (nextShift[12:8])
                  `LCC_ADDR_MAIN:    d.mainCtl = {3'h0, nextShift[4:0]};
                  `LCC_ADDR_MANDLY:  d.manDelay = {4'h0, nextShift[3:0]}; // RULE6
                  `LCC_ADDR_DEBUG:   d.linkDbg = {4'h0, nextShift[3], 3'h0}; // RULE11
                  `LCC_ADDR_LINKEXT: d.linkExt = nextShift[7:0];
                  `LCC_ADDR_CONVEXT: d.convExt = nextShift[7:0];
                  `LCC_ADDR_PREDIV:  d.preDiv = nextShift[7:0];
                  `LCC_ADDR_IOSEL1:  d.ioSel1 = nextShift[7:0];
                  `LCC_ADDR_IOSEL2:  d.ioSel2 = {nextShift[7:6], 2'b00, nextShift[3:2], 2'b00};
                  default:           d.page = q.page;
                endcase
              end
            end
          end
        end
      end
      LCC_DONE: begin
        d.phase = LCC_DONE;
      end
      default: begin
        d.phase = LCC_IDLE;
      end
    endcase
    // raising chip select aborts a frame; a partial write stores nothing
    if (spiIn.csN) begin
      d.phase = LCC_IDLE;
      d.sdo   = 1'b0;
    end
    // software or supervisor owns power-down
    d.ctrl.linkRxPowerdown = q.mainCtl[`LCC_BIT_PDSEL] ? q.mainCtl[`LCC_BIT_LINKPD] // RULE1 RULE2
                                                      : supervisorPowerdown;         // RULE2
    d.ctrl.clockDelay = q.mainCtl[`LCC_BIT_CALSEL] ? q.manDelay[3:0] // RULE4 RULE5 RULE6
                                                   : autoDelay;      // RULE3
    d.ctrl.simpleErrorTest = q.linkDbg[`LCC_BIT_SIMPLE_ERROR_RATE_TEST]; // RULE11
    // stretch counters reload while the bit is held, then count down on their own domain rate
    if (q.mainCtl[`LCC_BIT_LINKRST]) begin
      d.linkCnt = q.linkExt; // RULE10
    end else if (linkClkTick && q.linkCnt != 8'h00) begin
      d.linkCnt = q.linkCnt - 8'h01; // RULE7
    end
    if (q.mainCtl[`LCC_BIT_CONVRST]) begin
      d.convCnt = q.convExt; // RULE10
    end else if (convClkTick && q.convCnt != 8'h00) begin
      d.convCnt = q.convCnt - 8'h01; // RULE8
    end
    d.ctrl.linkDomainReset = q.mainCtl[`LCC_BIT_LINKRST] || (q.linkCnt != 8'h00); // RULE7 RULE10
    d.ctrl.convDomainReset = q.mainCtl[`LCC_BIT_CONVRST] || (q.convCnt != 8'h00); // RULE8 RULE10
    // interval is predivider+1 link periods so a zero value still ticks
    d.ctrl.supervisorTick = 1'b0;
    if (linkClkTick) begin
      if (q.divCnt == 8'h00) begin
        d.divCnt              = q.preDiv; // RULE9
        d.ctrl.supervisorTick = 1'b1;     // RULE9
      end else begin
        d.divCnt = q.divCnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q          <= '0;
      q.mainCtl  <= `LCC_RST_MAIN;
      q.linkExt  <= `LCC_RST_LINKEXT;
      q.convExt  <= `LCC_RST_CONVEXT;
      q.preDiv   <= `LCC_RST_PREDIV;
      q.ioSel1   <= `LCC_RST_IOSEL;
      q.ioSel2   <= `LCC_RST_IOSEL;
      q.phase    <= LCC_IDLE;
      q.ctrl.linkDomainReset <= 1'b1;
      q.ctrl.convDomainReset <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign ctrl        = q.ctrl;
  assign spiOut = lcc_spi_out_s'{
    sdo:   q.sdo,
    sdoOe: (q.phase == LCC_DATA) && q.readOp && !spiIn.csN
  };

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // an extension of one period may end at the very next tick, so the two-cycle hold needs two or more
  sequence linkRelease;
    $fell(q.mainCtl[`LCC_BIT_LINKRST]) && q.linkExt > 8'h01;
  endsequence
  sequence convRelease;
    $fell(q.mainCtl[`LCC_BIT_CONVRST]) && q.convExt > 8'h01;
  endsequence

  a_sw_powerdown: assert property (q.mainCtl[`LCC_BIT_PDSEL] |=> ctrl.linkRxPowerdown == $past(q.mainCtl[`LCC_BIT_LINKPD])) // RULE1
    else $error("software power-down not applied");
  a_sup_powerdown: assert property (!q.mainCtl[`LCC_BIT_PDSEL] |=> ctrl.linkRxPowerdown == $past(supervisorPowerdown)) // RULE2
    else $error("supervisor power-down not applied");
  a_auto_delay: assert property (!q.mainCtl[`LCC_BIT_CALSEL] |=> ctrl.clockDelay == $past(autoDelay)) // RULE3
    else $error("automatic delay not applied");
  a_manual_delay: assert property (q.mainCtl[`LCC_BIT_CALSEL] |=> ctrl.clockDelay == $past(q.manDelay[3:0])) // RULE4
    else $error("manual delay not applied");
  a_manual_ignored: assert property (!q.mainCtl[`LCC_BIT_CALSEL] && $changed(q.manDelay) && $stable(autoDelay)
                                     |=> $stable(ctrl.clockDelay)) // RULE5
    else $error("manual delay leaked while automatic");
  a_delay_width: assert property (q.manDelay[7:4] == 4'h0) // RULE6
    else $error("manual delay upper bits set");
  a_link_stretch: assert property (linkRelease |=> ctrl.linkDomainReset [*2]) // RULE7
    else $error("link reset not stretched");
  a_conv_stretch: assert property (convRelease |=> ctrl.convDomainReset [*2]) // RULE8
    else $error("converter reset not stretched");
  a_prediv_tick: assert property (linkClkTick && q.divCnt == 8'h00 |=> ctrl.supervisorTick && q.divCnt == $past(q.preDiv)) // RULE9
    else $error("supervisor interval wrong");
  a_reset_hold: assert property (q.mainCtl[`LCC_BIT_LINKRST] |=> ctrl.linkDomainReset) // RULE10
    else $error("link domain not held in reset");
  a_ber_enable: assert property (ctrl.simpleErrorTest == $past(q.linkDbg[`LCC_BIT_SIMPLE_ERROR_RATE_TEST]) && q.linkDbg[2:0] == 3'h0) // RULE11
    else $error("error test enable wrong");
  a_conv_hold: assert property (q.mainCtl[`LCC_BIT_CONVRST] |=> ctrl.convDomainReset) // RULE10
    else $error("converter domain not held in reset");
  a_link_count: assert property (q.linkCnt != 8'h00 |=> ctrl.linkDomainReset) // RULE7
    else $error("link reset dropped while stretching");
  a_conv_count: assert property (q.convCnt != 8'h00 |=> ctrl.convDomainReset) // RULE8
    else $error("converter reset dropped while stretching");
  a_link_ext_zero: assert property ($fell(q.mainCtl[`LCC_BIT_LINKRST]) && q.linkExt == 8'h00 |=> !ctrl.linkDomainReset) // RULE7
    else $error("link reset stretched with zero extension");
  a_conv_ext_zero: assert property ($fell(q.mainCtl[`LCC_BIT_CONVRST]) && q.convExt == 8'h00 |=> !ctrl.convDomainReset) // RULE8
    else $error("converter reset stretched with zero extension");
  a_frame_abort: assert property (spiIn.csN |=> q.phase == LCC_IDLE && !q.sdo)
    else $error("frame not abandoned on deselect");
  a_idle_quiet: assert property (q.phase == LCC_IDLE |-> !spiOut.sdoOe)
    else $error("read data driven while idle");
endmodule

// ---- testbench/lcc_spi_host.sv ----
`timescale 1ns/1ps
module lcc_spi_host (
  // clock
  input  wire logic                  clk,
  // serial lines
  output lcc_pkg::lcc_spi_in_s       spiIn,
  input  wire lcc_pkg::lcc_spi_out_s spiOut
);
  import lcc_pkg::*;
  initial spiIn = '{csN: 1'b1, sclk: 1'b0, sdi: 1'b0};
  // each sclk level is held 3 clk cycles, above the 1-cycle minimum the port needs
  task automatic xfer(input logic rdOp, input logic [4:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata, output logic oeOk);
    logic [15:0] frame;
    frame = {rdOp, 2'b00, addr, wdata};
    rdata = 8'h00;
    oeOk  = 1'b1;
    @(posedge clk) spiIn.csN <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk) spiIn.sdi <= frame[i];
      repeat (2) @(posedge clk);
      spiIn.sclk <= 1'b1;
      repeat (3) @(posedge clk);
      // data bit 7 stands from the 8th rise, each later bit from a fall, until the next fall
      if (i >= 1 && i <= 8) begin
        rdata[i-1] = spiOut.sdo;
        oeOk       = oeOk && (spiOut.sdoOe === rdOp);
      end
      spiIn.sclk <= 1'b0;
    end
    // released data line shows the inverse, not a stale copy
    @(posedge clk) spiIn.sdi <= ~frame[0];
    spiIn.csN <= 1'b1;
    @(posedge clk);
    oeOk = oeOk && (spiOut.sdoOe === 1'b0);
  endtask
endmodule

// ---- testbench/test_lvds_clock_calib_ctrl_regs.sv ----
`timescale 1ns/1ps
`include "lcc_cfg.svh"
module test_lvds_clock_calib_ctrl_regs;
  import lcc_pkg::*;
  logic         clk, resetn, linkClkTick, convClkTick, supervisorPowerdown;
  logic [3:0]   autoDelay;
  lcc_spi_in_s  spiIn;
  lcc_spi_out_s spiOut;
  lcc_ctrl_s    ctrl;
  int           err_total, num_checks, cyc, lc, cc;
  logic [7:0]   rd, wv, mv;
  logic [4:0]   ra [14] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h11, 5'h12,
                            5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f, 5'h03};
  logic [7:0]   rv [14] = '{8'h03, 8'h00, 8'h00, 8'h3f, 8'h20, 8'h1d, 8'h80, 8'h80,
                            8'h5a, 8'h11, 8'h12, 8'h13, 8'h00, 8'h00};
  logic [7:0]   wm [8]  = '{8'h1f, 8'h0f, 8'h08, 8'hff, 8'hff, 8'hff, 8'hff, 8'hcc};

  lcc_regs uut (.clk(clk), .resetn(resetn), .spiIn(spiIn), .spiOut(spiOut), .linkClkTick(linkClkTick),
                .convClkTick(convClkTick), .supervisorPowerdown(supervisorPowerdown),
                .autoDelay(autoDelay), .ctrl(ctrl));
  lcc_spi_host host (.clk(clk), .spiIn(spiIn), .spiOut(spiOut));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // slow rate enables keep the host's frame tail under one tick period
  always @(posedge clk) begin
    cyc <= cyc + 1;
    linkClkTick <= (cyc % 8) == 0;
    convClkTick <= (cyc % 12) == 0;
  end

  function automatic logic expPd(input logic [7:0] m, input logic s);
    return m[`LCC_BIT_PDSEL] ? m[`LCC_BIT_LINKPD] : s;
  endfunction
  function automatic logic [3:0] expDly(input logic [7:0] m, input logic [7:0] man, input logic [3:0] a);
    return m[`LCC_BIT_CALSEL] ? man[3:0] : a;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    logic       oe;
    host.xfer(1'b0, a, d, dummy, oe);
    chk({7'h00, oe}, 8'h01);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] got;
    logic       oe;
    host.xfer(1'b1, a, 8'h00, got, oe);
    chk(got, exp);
    chk({7'h00, oe}, 8'h01);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #400us;
    err_total++;
    end_of_test();
  end

  initial begin
    cyc = 0;
    err_total = 0;
    num_checks = 0;
    resetn = 1'b0;
    linkClkTick = 1'b0;
    convClkTick = 1'b0;
    supervisorPowerdown = 1'b0;
    autoDelay = 4'h0;
    void'($urandom(32'h8e62_1eca));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    chk(ctrl.linkDomainReset, 1'b1);
    for (int i = 0; i < 14; i++) rdchk(ra[i], rv[i]);
    // foreign page hides the map and drops writes
    wr(`LCC_ADDR_PAGE, 8'h01);
    rdchk(`LCC_ADDR_MAIN, 8'h00);
    wr(`LCC_ADDR_PREDIV, 8'h55);
    wr(`LCC_ADDR_PAGE, 8'h00);
    rdchk(`LCC_ADDR_PREDIV, 8'h1d);
    wr(`LCC_ADDR_TYPE, 8'hff);
    rdchk(`LCC_ADDR_TYPE, 8'h5a);
    for (int i = 0; i < 8; i++) begin
      wv = 8'($urandom);
      wr(ra[i], wv);
      rdchk(ra[i], wv & wm[i]);
    end
    for (int i = 0; i < 8; i++) begin
      mv = (i < 4) ? {3'b000, i[1], i[0], i[0], 2'b00} : (8'($urandom) & 8'h1c);
      wv = 8'($urandom);
      supervisorPowerdown <= 1'($urandom);
      autoDelay <= 4'($urandom);
      wr(`LCC_ADDR_MAIN, mv);
      wr(`LCC_ADDR_MANDLY, wv);
      repeat (2) @(posedge clk);
      chk(ctrl.linkRxPowerdown, expPd(mv, supervisorPowerdown));
      chk(ctrl.clockDelay, expDly(mv, wv, autoDelay));
    end
    for (int i = 0; i < 2; i++) begin
      wr(`LCC_ADDR_DEBUG, {4'h0, i[0], 3'b111});
      @(posedge clk);
      chk(ctrl.simpleErrorTest, i[0]);
    end
    wr(`LCC_ADDR_LINKEXT, 8'h04);
    wr(`LCC_ADDR_CONVEXT, 8'h03);
    wr(`LCC_ADDR_MAIN, 8'h03);
    repeat (40) @(posedge clk);
    chk({ctrl.linkDomainReset, ctrl.convDomainReset}, 2'b11);
    wr(`LCC_ADDR_MAIN, 8'h00);
    lc = 0;
    cc = 0;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      if (ctrl.linkDomainReset === 1'b1 && linkClkTick === 1'b1) lc++;
      if (ctrl.convDomainReset === 1'b1 && convClkTick === 1'b1) cc++;
    end
    chk(ctrl.linkDomainReset || lc < 3 || lc > 4, 1'b0);
    chk(ctrl.convDomainReset || cc < 2 || cc > 3, 1'b0);
    // zero extension: the domain resets drop right after the bits clear
    wr(`LCC_ADDR_LINKEXT, 8'h00);
    wr(`LCC_ADDR_CONVEXT, 8'h00);
    wr(`LCC_ADDR_MAIN, 8'h03);
    wr(`LCC_ADDR_MAIN, 8'h00);
    chk({ctrl.linkDomainReset, ctrl.convDomainReset}, 2'b00);
    wr(`LCC_ADDR_PREDIV, 8'h03);
    lc = 0;
    // the count under way may still run from an earlier random predivider
    while (ctrl.supervisorTick !== 1'b1 && lc < 3000) begin
      @(posedge clk);
      lc++;
    end
    cc = 0;
    do begin
      @(posedge clk);
      cc++;
    end while (ctrl.supervisorTick !== 1'b1 && cc < 200);
    chk(8'(cc), 8'd32);
    // a second reset mid-run brings the map back to its defaults
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    chk(ctrl.linkDomainReset, 1'b1);
    rdchk(`LCC_ADDR_PREDIV, `LCC_RST_PREDIV);
    end_of_test();
  end
endmodule
